/* File: hw/dpu_dual_pointer.sv */
// dpu_dual_pointer.sv: dual 16-bit data pointer unit with its control registers
// assumes: cpu decoder issues pointer commands and sfr accesses on clk_i; boot strap is a pin
`timescale 1ns/100ps
`include "dpu_map.svh"

// Functional notes
// - two independent 16-bit pointers, zero and one, address code or data
// - select 0: normal is pointer zero, alternate pointer one; select 1: swapped
// - selected pointer read and written as low/high bytes at 82H and 83H
// - unselected pointer read and written as low/high bytes at D4H and D5H
// - changing select swaps register pair mapping, stored values unchanged
// - auxiliary bit 2 always reads zero so incrementing toggles select
// - prefix A5H inverts select for one instruction, including immediate load
// - indirect jump via pointer plus accumulator ignores the prefix
// - decrement bit turns pointer increment into decrement, normal or prefixed
// - update bit adjusts pointer by one after external data or code moves
// - automatic adjust direction follows that pointer's decrement bit
// - boot map bit 1 overlays boot rom on F800H-FFFFH, else program memory
// - boot map bit resets from the bootloader jump strap
// - extended stack bit moves stack from 256-byte internal to 2K expanded
// - user flag three is plain read/write storage
// - auxiliary register at A2H, not bit addressable, defined bits reset zero except the boot map bit
// - update/decrement bits in config register A1H bits 7:4, reset zero
// - update set: decrement 0 post-increments, 1 post-decrements; clear: none
module dpu_dual_pointer
   import dpu_pkg::*;
(
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         reset_n_i,
   // sfr access
   input  wire dpu_sfr_req_t sfr_req_i,
   output logic       [7:0]  sfr_rdata_o,
   output logic              sfr_hit_o,
   // opcode fetch and pointer commands
   input  wire logic         fetch_valid_i,
   input  wire logic   [7:0] fetch_opcode_i,
   input  wire dpu_cmd_t     cmd_i,
   output logic      [15:0]  ptr_addr_o,
   // program memory map
   input  wire logic  [15:0] prog_addr_i,
   output logic              boot_rom_select_o,
   // strap and mode outputs
   input  wire logic         boot_jump_cfg_i,
   output logic              pointer_select_o,
   output logic              boot_rom_map_enable_o,
   output logic              extended_stack_enable_o,
   output logic      [11:0]  stack_limit_o
);

   // ****************************************************************
   // decode helpers
   // ****************************************************************
   // physical pointer index from select and alternate flag
   function automatic logic phys_index(input logic sel, input logic alt);
      return sel ^ alt;
   endfunction

   // true for the alternate register pair
   function automatic logic is_alt_pair(input logic [7:0] addr);
      return (addr == `DPU_SFR_ALT_LOW) || (addr == `DPU_SFR_ALT_HIGH);
   endfunction

   // true for any pointer byte address
   function automatic logic is_ptr_sfr(input logic [7:0] addr);
      return (addr == `DPU_SFR_SEL_LOW) || (addr == `DPU_SFR_SEL_HIGH) || is_alt_pair(addr);
   endfunction

   // true for a low byte address
   function automatic logic is_low_byte(input logic [7:0] addr);
      return (addr == `DPU_SFR_SEL_LOW) || (addr == `DPU_SFR_ALT_LOW);
   endfunction

   // ****************************************************************
   // reset release and strap capture
   // ****************************************************************
   logic [1:0]     rst_sync;
   logic           rst_n;
   logic [1:0]     strap_sync;
   logic           strap_done;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // strap sampled without reset so it is settled at release
   always_ff @(posedge clk_i) begin
      strap_sync <= {strap_sync[0], boot_jump_cfg_i};
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         strap_done <= 1'b0;
      end else begin
         strap_done <= 1'b1;
      end
   end

   // ****************************************************************
   // control registers
   // ****************************************************************
   logic           pointer_select;
   logic           user_flag_three;
   logic           extended_stack_enable;
   logic           boot_rom_map_enable;
   logic [3:0]     pointer_config;
   logic           aux_wr;
   logic           cfg_wr;

   assign aux_wr = sfr_req_i.wr && (sfr_req_i.addr == `DPU_SFR_AUX_ONE);
   assign cfg_wr = sfr_req_i.wr && (sfr_req_i.addr == `DPU_SFR_CONFIG);

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pointer_select <= 1'b0;
      end else if (aux_wr) begin
         pointer_select <= sfr_req_i.wdata[`DPU_AUX_SELECT_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         user_flag_three <= 1'b0;
         extended_stack_enable <= 1'b0;
      end else if (aux_wr) begin
         user_flag_three <= sfr_req_i.wdata[`DPU_AUX_FLAG3_BIT];
         extended_stack_enable <= sfr_req_i.wdata[`DPU_AUX_EXTENDED_STACK_ENABLE_BIT];
      end
   end

   // first edge after release loads the strap; a boot bit write in that cycle is lost
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         boot_rom_map_enable <= 1'b0;
      end else if (!strap_done) begin
         boot_rom_map_enable <= strap_sync[1];
      end else if (aux_wr) begin
         boot_rom_map_enable <= sfr_req_i.wdata[`DPU_AUX_BOOT_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pointer_config <= `DPU_CFG_RESET;
      end else if (cfg_wr) begin
         pointer_config <= sfr_req_i.wdata[7:`DPU_CFG_FIELD_LSB];
      end
   end

   // per pointer mode bits, index is the physical pointer
   logic [1:0]     ptr_dec;
   logic [1:0]     ptr_upd;
   assign ptr_dec = {pointer_config[`DPU_CFG_DEC1_BIT - `DPU_CFG_FIELD_LSB],
                     pointer_config[`DPU_CFG_DEC0_BIT - `DPU_CFG_FIELD_LSB]};
   assign ptr_upd = {pointer_config[`DPU_CFG_UPD1_BIT - `DPU_CFG_FIELD_LSB],
                     pointer_config[`DPU_CFG_UPD0_BIT - `DPU_CFG_FIELD_LSB]};

   // ****************************************************************
   // prefix tracking
   // ****************************************************************
   dpu_pfx_state_t pfx_state;
   logic           use_alt;
   logic           op_index;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pfx_state <= DPU_PFX_IDLE;
      end else begin
         unique case (pfx_state)
            DPU_PFX_IDLE: begin
               if (fetch_valid_i && (fetch_opcode_i == `DPU_PREFIX_OPCODE)) begin
                  pfx_state <= DPU_PFX_ARMED;
               end
            end
            DPU_PFX_ARMED: begin
               if (cmd_i.valid) begin
                  pfx_state <= DPU_PFX_IDLE;
               end
            end
         endcase
      end
   end

   // jump keeps the selected pointer even when prefixed
   assign use_alt  = (pfx_state == DPU_PFX_ARMED) && (cmd_i.op != DPU_OP_JMP);
   assign op_index = phys_index(pointer_select, use_alt);

   // ****************************************************************
   // pointers
   // ****************************************************************
   logic [15:0]    ptr_q    [2];
   logic [15:0]    stepped  [2];
   logic [15:0]    next_ptr [2];
   logic           sfr_ptr_wr;
   logic           sfr_index;

   assign sfr_ptr_wr = sfr_req_i.wr && is_ptr_sfr(sfr_req_i.addr);
   assign sfr_index  = phys_index(pointer_select, is_alt_pair(sfr_req_i.addr));

   generate
      for (genvar gi = 0; gi < 2; gi++) begin : g_ptr
         dpu_ptr_step u_step (
            .value_i     (ptr_q[gi]),
            .decrement_i (ptr_dec[gi]),
            .value_o     (stepped[gi])
         );

         // sfr byte write wins over an instruction update of the same byte
         always_comb begin
            next_ptr[gi] = ptr_q[gi];
            if (cmd_i.valid && (op_index == 1'(gi))) begin
               unique case (cmd_i.op)
                  DPU_OP_LOAD_IMM: next_ptr[gi] = cmd_i.imm;
                  DPU_OP_INC:      next_ptr[gi] = stepped[gi];
                  DPU_OP_EXTERNAL_DATA_MOVE,
                  DPU_OP_CODE_MEMORY_MOVE: begin
                     if (ptr_upd[gi]) begin
                        next_ptr[gi] = stepped[gi];
                     end
                  end
                  default:         next_ptr[gi] = ptr_q[gi];                // none, jump and unused codes hold
               endcase
            end
            if (sfr_ptr_wr && (sfr_index == 1'(gi))) begin
               if (is_low_byte(sfr_req_i.addr)) begin
                  next_ptr[gi][7:0] = sfr_req_i.wdata;
               end else begin
                  next_ptr[gi][15:8] = sfr_req_i.wdata;
               end
            end
         end

         always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
               ptr_q[gi] <= `DPU_PTR_RESET;
            end else begin
               ptr_q[gi] <= next_ptr[gi];
            end
         end
      end
   endgenerate

   // address for the current command, combinational from the pointer flops
   assign ptr_addr_o = ptr_q[op_index];

   // ****************************************************************
   // sfr read port
   // ****************************************************************
   logic [7:0]     rd_value;
   logic           rd_hit;
   logic [15:0]    rd_ptr;

   assign rd_ptr = ptr_q[sfr_index];

   always_comb begin
      rd_value = `DPU_SFR_IDLE;
      rd_hit   = 1'b1;
      if (is_ptr_sfr(sfr_req_i.addr)) begin
         rd_value = is_low_byte(sfr_req_i.addr) ? rd_ptr[7:0] : rd_ptr[15:8];
      end else if (sfr_req_i.addr == `DPU_SFR_AUX_ONE) begin
         rd_value[`DPU_AUX_SELECT_BIT] = pointer_select;
         rd_value[`DPU_AUX_ZERO_BIT]   = 1'b0;
         rd_value[`DPU_AUX_FLAG3_BIT]  = user_flag_three;
         rd_value[`DPU_AUX_EXTENDED_STACK_ENABLE_BIT]   = extended_stack_enable;
         rd_value[`DPU_AUX_BOOT_BIT]   = boot_rom_map_enable;
      end else if (sfr_req_i.addr == `DPU_SFR_CONFIG) begin
         rd_value[7:`DPU_CFG_FIELD_LSB] = pointer_config;
      end else begin
         rd_hit = 1'b0;
      end
   end

   assign sfr_hit_o = (sfr_req_i.rd || sfr_req_i.wr) && rd_hit;

   // unmapped reads return zero
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata_o <= `DPU_SFR_IDLE;
      end else if (sfr_req_i.rd) begin
         sfr_rdata_o <= rd_value;
      end
   end

   // ****************************************************************
   // mode outputs
   // ****************************************************************
   assign boot_rom_select_o = boot_rom_map_enable && (prog_addr_i >= `DPU_BOOT_BASE);
   assign pointer_select_o        = pointer_select;
   assign boot_rom_map_enable_o   = boot_rom_map_enable;
   assign extended_stack_enable_o = extended_stack_enable;
   assign stack_limit_o = extended_stack_enable ? `DPU_STACK_EXT_LIMIT : `DPU_STACK_INT_LIMIT;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n);

   property p_swap_keeps_values;
      (aux_wr && !cmd_i.valid && !sfr_ptr_wr) |=> ($stable(ptr_q[0]) && $stable(ptr_q[1]));
   endproperty
   a_swap_keeps_values: assert property (p_swap_keeps_values) else $error("select change altered a pointer");

   property p_sel_low_read;
      (sfr_req_i.rd && (sfr_req_i.addr == `DPU_SFR_SEL_LOW) && !sfr_req_i.wr && !cmd_i.valid)
         |=> (sfr_rdata_o == $past(ptr_q[pointer_select][7:0]));
   endproperty
   a_sel_low_read: assert property (p_sel_low_read) else $error("selected low byte read wrong");

   property p_alt_high_read;
      (sfr_req_i.rd && (sfr_req_i.addr == `DPU_SFR_ALT_HIGH) && !sfr_req_i.wr && !cmd_i.valid)
         |=> (sfr_rdata_o == $past(ptr_q[!pointer_select][15:8]));
   endproperty
   a_alt_high_read: assert property (p_alt_high_read) else $error("alternate high byte read wrong");

   property p_aux_bit2_zero;
      (sfr_req_i.rd && (sfr_req_i.addr == `DPU_SFR_AUX_ONE)) |=> !sfr_rdata_o[`DPU_AUX_ZERO_BIT];
   endproperty
   a_aux_bit2_zero: assert property (p_aux_bit2_zero) else $error("auxiliary bit 2 read as one");

   property p_prefix_load;
      (pfx_state == DPU_PFX_ARMED && cmd_i.valid && cmd_i.op == DPU_OP_LOAD_IMM && !sfr_req_i.wr)
         |=> (ptr_q[!$past(pointer_select)] == $past(cmd_i.imm)) && (pfx_state == DPU_PFX_IDLE);
   endproperty
   a_prefix_load: assert property (p_prefix_load) else $error("prefixed load missed alternate pointer");

   property p_jump_ignores_prefix;
      (cmd_i.valid && cmd_i.op == DPU_OP_JMP) |-> (ptr_addr_o == ptr_q[pointer_select]);
   endproperty
   a_jump_ignores_prefix: assert property (p_jump_ignores_prefix) else $error("jump used wrong pointer");

   property p_inc_direction;
      (cmd_i.valid && cmd_i.op == DPU_OP_INC && !sfr_req_i.wr)
         |=> (ptr_q[$past(op_index)] == ($past(ptr_dec[op_index]) ? $past(ptr_q[op_index]) - 16'h0001
                                                                   : $past(ptr_q[op_index]) + 16'h0001));
   endproperty
   a_inc_direction: assert property (p_inc_direction) else $error("pointer step direction wrong");

   property p_move_update;
      (cmd_i.valid && (cmd_i.op == DPU_OP_EXTERNAL_DATA_MOVE || cmd_i.op == DPU_OP_CODE_MEMORY_MOVE) && !sfr_req_i.wr)
         |=> (ptr_q[$past(op_index)] == (!$past(ptr_upd[op_index]) ? $past(ptr_q[op_index]) :
              $past(ptr_dec[op_index]) ? $past(ptr_q[op_index]) - 16'h0001 : $past(ptr_q[op_index]) + 16'h0001));
   endproperty
   a_move_update: assert property (p_move_update) else $error("move post-update wrong");

   property p_boot_map;
      boot_rom_select_o == (boot_rom_map_enable && prog_addr_i[15:11] == 5'b11111);
   endproperty
   a_boot_map: assert property (p_boot_map) else $error("boot rom window decode wrong");

   property p_cfg_low_zero;
      (sfr_req_i.rd && (sfr_req_i.addr == `DPU_SFR_CONFIG)) |=> (sfr_rdata_o[3:0] == 4'h0);
   endproperty
   a_cfg_low_zero: assert property (p_cfg_low_zero) else $error("config low bits not zero");

endmodule

/* File: hw/dpu_map.svh */
// dpu_map.svh: offsets, field positions, reset values and constants of the dual data pointer unit
// assumes: included by the design files and the bench by its bare name
`ifndef DPU_MAP_SVH
`define DPU_MAP_SVH

// ****************************************************************
// special function register addresses
// ****************************************************************
`define DPU_SFR_SEL_LOW      8'h82
`define DPU_SFR_SEL_HIGH     8'h83
`define DPU_SFR_CONFIG       8'hA1
`define DPU_SFR_AUX_ONE      8'hA2
`define DPU_SFR_ALT_LOW      8'hD4
`define DPU_SFR_ALT_HIGH     8'hD5

// ****************************************************************
// auxiliary_control_one fields
// ****************************************************************
`define DPU_AUX_SELECT_BIT   0
`define DPU_AUX_ZERO_BIT     2
`define DPU_AUX_FLAG3_BIT    3
`define DPU_AUX_EXTENDED_STACK_ENABLE_BIT     4
`define DPU_AUX_BOOT_BIT     5

// ****************************************************************
// pointer_config fields
// ****************************************************************
`define DPU_CFG_DEC0_BIT     4
`define DPU_CFG_DEC1_BIT     5
`define DPU_CFG_UPD0_BIT     6
`define DPU_CFG_UPD1_BIT     7
`define DPU_CFG_FIELD_LSB    4
`define DPU_CFG_RESET        4'h0

// ****************************************************************
// reset values and constants
// ****************************************************************
`define DPU_PTR_RESET        16'h0000
`define DPU_SFR_IDLE         8'h00
`define DPU_PREFIX_OPCODE    8'hA5
`define DPU_BOOT_BASE        16'hF800
`define DPU_STACK_INT_LIMIT  12'h100
`define DPU_STACK_EXT_LIMIT  12'h800
`define DPU_PTR_STEP         16'h0001

`endif

/* File: hw/dpu_pkg.sv */
// dpu_pkg.sv: types shared by the dual data pointer unit
// assumes: the map header supplies every number
package dpu_pkg;

   // pointer operations issued by the instruction decoder
   typedef enum logic [2:0] {
      DPU_OP_NONE,
      DPU_OP_LOAD_IMM,
      DPU_OP_INC,
      DPU_OP_EXTERNAL_DATA_MOVE,
      DPU_OP_CODE_MEMORY_MOVE,
      DPU_OP_JMP
   } dpu_op_t;

   // prefix tracking
   typedef enum logic {
      DPU_PFX_IDLE,
      DPU_PFX_ARMED
   } dpu_pfx_state_t;

   // special function register access
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dpu_sfr_req_t;

   // pointer command from the decoder
   typedef struct packed {
      logic       valid;
      dpu_op_t    op;
      logic [15:0] imm;
   } dpu_cmd_t;

endpackage

/* File: hw/dpu_ptr_step.sv */
// dpu_ptr_step.sv: one-step increment or decrement of a 16-bit pointer
// assumes: purely combinational, used once per pointer
`timescale 1ns/100ps
`include "dpu_map.svh"

module dpu_ptr_step
   import dpu_pkg::*;
(
   // operand
   input  wire logic [15:0] value_i,
   input  wire logic        decrement_i,
   // result
   output logic      [15:0] value_o
);

   // wraps modulo 65536, no flags touched
   assign value_o = decrement_i ? (value_i - `DPU_PTR_STEP) : (value_i + `DPU_PTR_STEP);

endmodule

/* File: verification/dpu_cpu_model.sv */
// dpu_cpu_model.sv: behavioural instruction decoder feeding pointer commands
// assumes: issue is entered shortly after a rising edge and returns just after one
`timescale 1ns/100ps

module dpu_cpu_model
   import dpu_pkg::*;
(
   // clock
   input  wire logic        clk_i,
   // address resolved by the unit
   input  wire logic [15:0] ptr_addr_i,
   // decoder outputs
   output logic             fetch_valid_o,
   output logic       [7:0] fetch_opcode_o,
   output dpu_cmd_t         cmd_o
);
   initial begin
      fetch_valid_o  = 1'b0;
      fetch_opcode_o = 8'h00;
      cmd_o          = '0;
   end

   // ****************************************************************
   // one instruction, optionally behind the prefix byte
   // ****************************************************************
   task automatic issue(input logic pfx, input dpu_op_t op, input logic [15:0] imm, output logic [15:0] addr);
      if (pfx) begin
         fetch_valid_o  = 1'b1;
         fetch_opcode_o = 8'hA5;
         @(posedge clk_i);
         #1;
      end
      // the instruction's own opcode fetch must not arm the prefix
      fetch_valid_o  = 1'b1;
      fetch_opcode_o = 8'h5A;
      cmd_o = {1'b1, op, imm};
      #2;
      addr = ptr_addr_i;
      @(posedge clk_i);
      #1;
      fetch_valid_o  = 1'b0;
      // stale immediate inverted so a late sample is caught
      cmd_o = {1'b0, DPU_OP_NONE, ~imm};
   endtask
endmodule

/* File: verification/dual_data_pointer_unit_tb_top.sv */
// dual_data_pointer_unit_tb_top.sv: self-checking bench for the dual data pointer unit
// assumes: cpu model issues commands; bench drives sfr bus, strap and program address
`timescale 1ns/100ps
`include "dpu_map.svh"

module dual_data_pointer_unit_tb_top
   import dpu_pkg::*;
;
   logic               clk_i = 1'b0;
   logic               reset_n_i, fetch_valid_i, boot_jump_cfg_i, sfr_hit_o, boot_rom_select_o;
   logic               pointer_select_o, boot_rom_map_enable_o, extended_stack_enable_o;
   logic         [7:0] fetch_opcode_i, sfr_rdata_o, cfg, aux;
   logic        [15:0] prog_addr_i, ptr_addr_o;
   logic        [11:0] stack_limit_o;
   logic        [15:0] p [2];
   dpu_sfr_req_t       sfr_req_i;
   dpu_cmd_t           cmd_i;
   int                 err_total = 0;
   int                 samples_checked = 0;
   logic         [7:0] regs [7] = '{8'h82, 8'h83, 8'hD4, 8'hD5, 8'hA1, 8'hA2, 8'h81};
   logic        [15:0] bd [4] = '{16'hF7FF, 16'hF800, 16'hFFFF, 16'h0000};

   dpu_dual_pointer uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o),
      .sfr_hit_o(sfr_hit_o), .fetch_valid_i(fetch_valid_i), .fetch_opcode_i(fetch_opcode_i), .cmd_i(cmd_i),
      .ptr_addr_o(ptr_addr_o), .prog_addr_i(prog_addr_i), .boot_rom_select_o(boot_rom_select_o),
      .boot_jump_cfg_i(boot_jump_cfg_i), .pointer_select_o(pointer_select_o),
      .boot_rom_map_enable_o(boot_rom_map_enable_o), .extended_stack_enable_o(extended_stack_enable_o),
      .stack_limit_o(stack_limit_o));
   dpu_cpu_model cpu (.clk_i(clk_i), .ptr_addr_i(ptr_addr_o), .fetch_valid_o(fetch_valid_i),
      .fetch_opcode_o(fetch_opcode_i), .cmd_o(cmd_i));

   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   // ****************************************************************
   // checking and closing
   // ****************************************************************
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   function automatic logic [7:0] expv(input logic [7:0] a);
      case (a)
         `DPU_SFR_SEL_LOW:  return p[aux[0]][7:0];
         `DPU_SFR_SEL_HIGH: return p[aux[0]][15:8];
         `DPU_SFR_ALT_LOW:  return p[!aux[0]][7:0];
         `DPU_SFR_ALT_HIGH: return p[!aux[0]][15:8];
         `DPU_SFR_CONFIG:   return cfg;
         `DPU_SFR_AUX_ONE:  return aux;
         default:           return 8'h00;
      endcase
   endfunction

   // ****************************************************************
   // sfr bus: one access, then one idle cycle
   // ****************************************************************
   task automatic sfr(input logic rd, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      sfr_req_i = {rd, ~rd, a, d};
      #2;
      chk("sfr hit", 16'(a inside {8'h82, 8'h83, 8'hA1, 8'hA2, 8'hD4, 8'hD5}), 16'(sfr_hit_o));
      @(posedge clk_i);
      #1;
      q = sfr_rdata_o;
      sfr_req_i = {2'b00, 8'($urandom), 8'($urandom)};
      @(posedge clk_i);
      #1;
   endtask

   task automatic rd_chk(input logic [7:0] a);
      logic [7:0] q;
      sfr(1'b1, a, 8'($urandom), q);
      chk($sformatf("register %h", a), 16'(expv(a)), 16'(q));
   endtask

   task automatic outs();
      chk("select", 16'(aux[0]), 16'(pointer_select_o));
      chk("boot map", 16'(aux[5]), 16'(boot_rom_map_enable_o));
      chk("ext stack", 16'(aux[4]), 16'(extended_stack_enable_o));
      chk("stack limit", aux[4] ? 16'h0800 : 16'h0100, 16'(stack_limit_o));
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      sfr(1'b0, a, d, q);
      case (a)
         `DPU_SFR_SEL_LOW:  p[aux[0]][7:0] = d;
         `DPU_SFR_SEL_HIGH: p[aux[0]][15:8] = d;
         `DPU_SFR_ALT_LOW:  p[!aux[0]][7:0] = d;
         `DPU_SFR_ALT_HIGH: p[!aux[0]][15:8] = d;
         `DPU_SFR_CONFIG:   cfg = d & 8'hF0;
         `DPU_SFR_AUX_ONE:  aux = d & 8'h39;
         default:           ;
      endcase
      outs();
   endtask

   // ****************************************************************
   // pointer command against the model
   // ****************************************************************
   task automatic run(input logic pfx, input dpu_op_t op, input logic [15:0] imm);
      logic [15:0] a;
      int          t;
      t = (op == DPU_OP_JMP) ? aux[0] : aux[0] ^ pfx;
      cpu.issue(pfx, op, imm, a);
      if (op != DPU_OP_NONE) chk("pointer address", p[t], a);
      case (op)
         DPU_OP_LOAD_IMM:          p[t] = imm;
         DPU_OP_INC:               p[t] = cfg[4+t] ? p[t] - 16'h0001 : p[t] + 16'h0001;
         DPU_OP_EXTERNAL_DATA_MOVE, DPU_OP_CODE_MEMORY_MOVE: if (cfg[6+t]) p[t] = cfg[4+t] ? p[t] - 16'h0001 : p[t] + 16'h0001;
         default:                  ;
      endcase
      for (int i = 0; i < 4; i++) rd_chk(regs[i]);
   endtask

   initial begin
      #1_000_000;
      err_total++;
      end_of_test();
   end

   initial begin
      logic [15:0] pa;
      logic  [7:0] sv [6];
      reset_n_i = 1'b0;
      sfr_req_i = '0;
      prog_addr_i = 16'h0000;
      void'($urandom(86755));
      boot_jump_cfg_i = 1'($urandom);
      p = '{16'h0000, 16'h0000};
      cfg = 8'h00;
      aux = {2'b00, boot_jump_cfg_i, 5'b00000};
      repeat (2) @(posedge clk_i);
      #1 reset_n_i = 1'b1;
      repeat (5) @(posedge clk_i);
      #1;
      foreach (regs[i]) rd_chk(regs[i]);
      outs();
      $display("test reset values done");
      for (int s = 0; s < 2; s++) begin
         wr(`DPU_SFR_AUX_ONE, {aux[7:1], s[0]});
         foreach (regs[i]) rd_chk(regs[i]);
         for (int i = 0; i < 4; i++) wr(regs[i], 8'($urandom));
         wr(regs[6], 8'($urandom));
         foreach (regs[i]) rd_chk(regs[i]);
      end
      $display("test pointer register pairs done");
      wr(`DPU_SFR_AUX_ONE, 8'hFF);
      rd_chk(`DPU_SFR_AUX_ONE);
      foreach (regs[i]) rd_chk(regs[i]);
      wr(`DPU_SFR_AUX_ONE, aux + 8'h01);
      foreach (regs[i]) rd_chk(regs[i]);
      foreach (bd[k]) begin
         prog_addr_i = bd[k];
         @(posedge clk_i);
         #1;
         chk("boot rom select", 16'(aux[5] && k > 0 && k < 3), 16'(boot_rom_select_o));
      end
      $display("test auxiliary control done");
      for (int n = 0; n < 300; n++) begin
         if ($urandom_range(3) == 0) wr(`DPU_SFR_CONFIG, 8'($urandom));
         if ($urandom_range(3) == 0) wr(`DPU_SFR_AUX_ONE, 8'($urandom));
         pa = (n % 2) ? 16'hF800 | 16'($urandom) : 16'($urandom);
         prog_addr_i = pa;
         run(1'($urandom), dpu_op_t'($urandom_range(5)), (n % 3 == 0) ? 16'hFFFF : 16'($urandom));
         chk("boot rom select", 16'(aux[5] && pa >= 16'hF800), 16'(boot_rom_select_o));
      end
      $display("test random pointer commands done");
      for (int i = 0; i < 6; i++) sfr(1'b1, regs[i], 8'h00, sv[i]);
      for (int i = 0; i < 6; i++) wr(regs[i], 8'($urandom));
      // select restored first so the pointer bytes land on the right pointer
      for (int i = 5; i >= 0; i--) wr(regs[i], sv[i]);
      foreach (sv[i]) chk("restored register", 16'(sv[i]), 16'(expv(regs[i])));
      foreach (regs[i]) rd_chk(regs[i]);
      $display("test context save restore done");
      wr(`DPU_SFR_CONFIG, 8'h00);
      rd_chk(`DPU_SFR_CONFIG);
      $display("test config clear done");
      end_of_test();
   end
endmodule
